// ===== swdq_top.sv
// Single-wire debug serial link with queue status output
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - Bits travel most significant first, nominally sixteen bus cycles each.
// - 512 cycles without host falling edge times out and clears command register.
// - Bit start seen 0-1 cycles after falling edge; sample ten cycles later.
// - Device never drives the wire while host is sending a bit.
// - Wire is pseudo-open-drain; device receives and sends both levels.
// - A returned one is a brief high pulse seven cycles after bit start.
// - A returned zero is low for 12 cycles, then a brief high drive.
// - Hardware commands run during normal execution, stealing cycles only when needed.
// - Firmware commands and debug ROM only exist in active background mode.
// - Movement codes valid at rising phase edge: none, latch, advance-bus, advance-latch.
// - Start codes valid at falling phase edge: none, interrupt, even, odd.
// - Movement refers to previous falling-edge data; start to cycle beginning now.
// - Queue holds two 16-bit stages and a latch feeding stage one.
// - Even start runs high byte of stage two; odd start runs low byte.
// - Queue gives three bytes at start; instructions finish before next starts.
// - Every command opcode is eight bits, optionally followed by address or data.
module swdq_top
    import swdq_pkg::*;
(
    input  wire logic        sys_clk_i,         // 40 MHz bus clock
    input  wire logic        rstn_i,            // Async reset, active low
    input  wire logic        debug_wire_pin_i,  // Debug wire level from pad
    output logic             debug_wire_pin_o,  // Level driven onto debug wire
    output logic             debug_wire_pin_oe_o, // Drive enable for debug wire
    input  wire logic        background_debug_mode_i, // Active background mode
    output logic             debug_rom_map_o,   // Debug ROM visible in map
    input  wire logic        tx_load_i,         // Load reply word to send
    input  wire logic [15:0] tx_word_i,         // Reply word, sent MSB first
    input  wire logic [4:0]  tx_bits_i,         // Number of reply bits
    output logic             cmd_valid_o,       // Opcode byte received, one pulse
    output logic      [7:0]  cmd_opcode_o,      // Received command opcode
    output logic      [15:0] rx_word_o,         // Shift register of received bits
    output logic             rx_bit_o,          // Received bit strobe, one pulse
    output logic             link_timeout_o,    // Timeout pulse
    output logic             tx_busy_o,         // Reply word pending or in flight
    input  wire logic        bus_phase_clock_i, // Bus phase clock pin
    input  wire logic [15:0] bus_data_i,        // Program fetch data
    input  wire logic [1:0]  move_req_i,        // Queue movement request
    input  wire logic [1:0]  start_req_i,       // Execution start request
    output logic      [1:0]  queue_status_pins_o, // Queue status pins
    output logic      [7:0]  opcode_o,          // Started opcode byte
    output logic      [15:0] stage2_o           // Queue stage two
);

    // ==================================================================
    // State
    // ==================================================================
    typedef struct packed {
        logic [1:0]  wsync;
        logic        wire_d;
        logic [1:0]  psync;
        swdq_link_t  link;
        logic [4:0]  bcnt;
        logic [9:0]  idle;
        logic [3:0]  cmd_bits;
        logic [7:0]  cmd;
        logic        cmd_valid;
        logic [15:0] rx;
        logic        rx_bit;
        logic [15:0] tx;
        logic [4:0]  tx_left;
        logic        tx_bit;
        logic        drv;
        logic        oe;
        logic        tmo;
        logic        rom_map;
        logic        tx_busy;
    } swdq_s_t;

    swdq_s_t s;
    swdq_s_t next_s;

    // Speed-up pulse lasts one cycle so the pad never fights a host edge
    function automatic logic is_cnt(input logic [4:0] c, input int unsigned v);
        is_cnt = (c == v[4:0]);
    endfunction

    logic fall;

    always_comb begin
        next_s           = s;
        next_s.wsync     = {s.wsync[0], debug_wire_pin_i};
        next_s.wire_d    = s.wsync[1];
        next_s.psync     = {s.psync[0], bus_phase_clock_i};
        next_s.cmd_valid = 1'b0;
        next_s.rx_bit    = 1'b0;
        next_s.tmo       = 1'b0;
        next_s.oe        = 1'b0;
        next_s.drv       = 1'b1;
        next_s.rom_map   = background_debug_mode_i;
        fall             = s.wire_d && !s.wsync[1] && !s.oe;

        // Reply word is taken only when no reply bits are left to send
        if (tx_load_i && s.tx_left == 5'h00) begin
            next_s.tx      = tx_word_i;
            next_s.tx_left = tx_bits_i;
        end

        if (fall) begin
            next_s.idle = CNT_RESET;
        end else if (s.idle != 10'(TIMEOUT_CYCLES - 1)) begin
            next_s.idle = s.idle + 10'h001;
        end

        case (s.link)
            SWDQ_IDLE: begin
                // Bit start perceived here, 0-1 cycles after the edge
                if (fall) begin
                    next_s.bcnt = 5'h01;
                    if (s.tx_left != 5'h00) begin
                        next_s.link   = SWDQ_TX;
                        next_s.tx_bit = s.tx[15];
                        next_s.tx     = {s.tx[14:0], 1'b0};
                    end else begin
                        next_s.link = SWDQ_RX;
                    end
                end
            end
            SWDQ_RX: begin
                // Pad stays released for the whole host bit
                next_s.bcnt = s.bcnt + 5'h01;
                if (is_cnt(s.bcnt, SAMPLE_CYCLES)) begin
                    next_s.rx       = {s.rx[14:0], s.wsync[1]};
                    next_s.rx_bit   = 1'b1;
                    // Stops at eight so a long data phase never fakes a second opcode
                    if (s.cmd_bits != 4'(CMD_BITS)) begin
                        next_s.cmd_bits = s.cmd_bits + 4'h1;
                    end
                    if (s.cmd_bits == 4'(CMD_BITS - 1)) begin
                        next_s.cmd       = {s.rx[6:0], s.wsync[1]};
                        next_s.cmd_valid = 1'b1;
                    end
                    next_s.link = SWDQ_IDLE;
                end
            end
            SWDQ_TX: begin
                next_s.bcnt = s.bcnt + 5'h01;
                if (s.tx_bit) begin
                    // One: single high pulse, host already released
                    next_s.oe = is_cnt(s.bcnt, ONE_PULSE_AT);
                    if (is_cnt(s.bcnt, ONE_PULSE_AT)) begin
                        next_s.link    = SWDQ_IDLE;
                        next_s.tx_left = s.tx_left - 5'h01;
                    end
                end else begin
                    // Zero: low for 12 cycles, then one high cycle
                    next_s.oe  = 1'b1;
                    next_s.drv = is_cnt(s.bcnt, ZERO_LOW_CYCLES);
                    if (s.bcnt == 5'(ZERO_LOW_CYCLES + 1)) begin
                        next_s.oe      = 1'b0;
                        next_s.link    = SWDQ_IDLE;
                        next_s.tx_left = s.tx_left - 5'h01;
                    end
                end
            end
            default: begin
                next_s.link = SWDQ_IDLE;
            end
        endcase

        // Timeout clears command and restarts framing
        if (!fall && s.idle == 10'(TIMEOUT_CYCLES - 2)) begin
            next_s.tmo      = 1'b1;
            next_s.cmd      = 8'h00;
            next_s.cmd_bits = 4'h0;
            next_s.rx       = 16'h0000;
            next_s.tx_left  = 5'h00;
            next_s.link     = SWDQ_IDLE;
            next_s.oe       = 1'b0;
            next_s.drv      = 1'b1;
        end

        // Busy is registered so the output comes straight from a flop
        next_s.tx_busy = (next_s.tx_left != 5'h00) || (next_s.link == SWDQ_TX);
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // ==================================================================
    // Queue status, phase clock already synchronised
    // ==================================================================
    logic [1:0]  q_status;
    logic [7:0]  q_opcode;
    logic [15:0] q_stage2;
    logic [1:0]  q_pins;
    logic [7:0]  q_op_r;
    logic [15:0] q_st2_r;

    swdq_queue u_queue (
        .sys_clk_i      (sys_clk_i),
        .rstn_i         (rstn_i),
        .bus_phase_i    (s.psync[1]),
        .bus_data_i     (bus_data_i),
        .move_req_i     (move_req_i),
        .start_req_i    (start_req_i),
        .queue_status_o (q_status),
        .opcode_o       (q_opcode),
        .stage2_o       (q_stage2)
    );

    // Already flops inside the queue; registered once more here for tidy outputs
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            q_pins  <= NO_MOVE_CODE;
            q_op_r  <= 8'h00;
            q_st2_r <= 16'h0000;
        end else begin
            q_pins  <= q_status;
            q_op_r  <= q_opcode;
            q_st2_r <= q_stage2;
        end
    end

    // Hardware commands are decoded outside and need no processor stall here
    assign debug_wire_pin_o    = s.drv;
    assign debug_wire_pin_oe_o = s.oe;
    assign debug_rom_map_o     = s.rom_map;
    assign cmd_valid_o         = s.cmd_valid;
    assign cmd_opcode_o        = s.cmd;
    assign rx_word_o           = s.rx;
    assign rx_bit_o            = s.rx_bit;
    assign link_timeout_o      = s.tmo;
    assign tx_busy_o           = s.tx_busy;
    assign queue_status_pins_o = q_pins;
    assign opcode_o            = q_op_r;
    assign stage2_o            = q_st2_r;

    // ==================================================================
    // Checks
    // ==================================================================
    sequence rx_start;
        s.link == SWDQ_IDLE && fall && s.tx_left == 5'h00;
    endsequence

    a_rx_no_drive : assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        rx_start |=> !debug_wire_pin_oe_o [*8])
        else $error("device drove wire during host bit");

    a_rx_sample_time : assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        rx_start |-> ##11 rx_bit_o)
        else $error("sample not ten cycles after start");

    a_one_pulse : assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (s.link == SWDQ_IDLE && fall && s.tx_left != 5'h00 && s.tx[15])
        |-> ##8 (debug_wire_pin_oe_o && debug_wire_pin_o) ##1 !debug_wire_pin_oe_o)
        else $error("one pulse misplaced");

    a_zero_low : assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (s.link == SWDQ_IDLE && fall && s.tx_left != 5'h00 && !s.tx[15] && s.idle < 10'h1D0)
        |=> ##1 (debug_wire_pin_oe_o && !debug_wire_pin_o) [*8])
        else $error("zero not held low");

    a_timeout_clear : assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        link_timeout_o |-> cmd_opcode_o == 8'h00 && s.cmd_bits == 4'h0 && !tx_busy_o)
        else $error("timeout did not clear");

    a_cmd_eight : assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        cmd_valid_o |-> $past(s.cmd_bits) == 4'h7)
        else $error("command not eight bits");

    a_rom_map : assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        debug_rom_map_o |-> $past(background_debug_mode_i))
        else $error("rom mapped outside background mode");

    a_status_pins : assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (s.psync[1] && !$past(s.psync[1])) |-> ##2 queue_status_pins_o == $past(move_req_i, 2))
        else $error("movement code not on pins");

    a_start_pins : assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (!s.psync[1] && $past(s.psync[1])) |-> ##2 queue_status_pins_o == $past(start_req_i, 2))
        else $error("start code not on pins");

endmodule : swdq_top

`default_nettype wire

// ===== swdq_pkg.sv
// Shared constants and types for the single-wire debug and queue status block
package swdq_pkg;

    // ==================================================================
    // Link timing in bus cycles
    // ==================================================================
    localparam int unsigned CLK_HZ          = 40000000;
    localparam int unsigned BIT_CYCLES      = 16;
    localparam int unsigned SAMPLE_CYCLES   = 10;
    localparam int unsigned ONE_PULSE_AT    = 7;
    localparam int unsigned ZERO_LOW_CYCLES = 13;
    localparam int unsigned TIMEOUT_CYCLES  = 512;
    localparam int unsigned CMD_BITS        = 8;
    localparam int unsigned WORD_BITS       = 16;
    localparam logic [9:0]  CNT_RESET       = 10'h000;

    // ==================================================================
    // Queue status codes
    // ==================================================================
    localparam logic [1:0] NO_MOVE_CODE          = 2'h0;
    localparam logic [1:0] LATCH_BUS_CODE        = 2'h1;
    localparam logic [1:0] ADVANCE_LOAD_BUS_CODE = 2'h2;
    localparam logic [1:0] ADVANCE_LOAD_LAT_CODE = 2'h3;
    localparam logic [1:0] NO_START_CODE         = 2'h0;
    localparam logic [1:0] INT_START_CODE        = 2'h1;
    localparam logic [1:0] EVEN_START_CODE       = 2'h2;
    localparam logic [1:0] ODD_START_CODE        = 2'h3;

    typedef enum logic [1:0] {
        SWDQ_IDLE,
        SWDQ_RX,
        SWDQ_TX
    } swdq_link_t;

endpackage : swdq_pkg

// ===== swdq_queue.sv
// Instruction queue model and time-multiplexed queue status output
`timescale 1ns/10ps
`default_nettype none

module swdq_queue
    import swdq_pkg::*;
(
    input  wire logic        sys_clk_i,      // Bus clock
    input  wire logic        rstn_i,         // Async reset, active low
    input  wire logic        bus_phase_i,    // Bus phase clock level, sampled
    input  wire logic [15:0] bus_data_i,     // Program fetch data
    input  wire logic [1:0]  move_req_i,     // Data movement request code
    input  wire logic [1:0]  start_req_i,    // Execution start request code
    output logic      [1:0]  queue_status_o, // Multiplexed status value
    output logic      [7:0]  opcode_o,       // Opcode byte being started
    output logic      [15:0] stage2_o        // Queue stage two contents
);

    typedef struct packed {
        logic        ph_d;
        logic [15:0] hold;
        logic [15:0] st1;
        logic [15:0] st2;
        logic [15:0] bus_fall;
        logic [1:0]  status;
        logic [7:0]  opcode;
    } swdq_q_t;

    swdq_q_t q;
    swdq_q_t next_q;

    always_comb begin
        next_q      = q;
        next_q.ph_d = bus_phase_i;
        // Falling edge: capture bus data and present the start code
        if (q.ph_d && !bus_phase_i) begin
            next_q.bus_fall = bus_data_i;
            next_q.status   = start_req_i;
            if (start_req_i == EVEN_START_CODE) begin
                next_q.opcode = q.st2[15:8];
            end else if (start_req_i == ODD_START_CODE) begin
                next_q.opcode = q.st2[7:0];
            end
        end
        // Rising edge: movement applies to data seen at previous fall
        if (!q.ph_d && bus_phase_i) begin
            next_q.status = move_req_i;
            case (move_req_i)
                LATCH_BUS_CODE: begin
                    next_q.hold = q.bus_fall;
                end
                ADVANCE_LOAD_BUS_CODE: begin
                    next_q.st2 = q.st1;
                    next_q.st1 = q.bus_fall;
                end
                ADVANCE_LOAD_LAT_CODE: begin
                    next_q.st2 = q.st1;
                    next_q.st1 = q.hold;
                end
                default: begin
                    next_q.st1 = q.st1;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign queue_status_o = q.status;
    assign opcode_o       = q.opcode;
    assign stage2_o       = q.st2;

    a_even_opcode : assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        ($past(q.ph_d) && !$past(bus_phase_i) && $past(start_req_i) == EVEN_START_CODE)
        |-> opcode_o == $past(q.st2[15:8]))
        else $error("even start opcode wrong");

    a_advance_move : assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (!q.ph_d && bus_phase_i && move_req_i[1]) |=> stage2_o == $past(q.st1))
        else $error("queue advance wrong");

endmodule : swdq_queue

`default_nettype wire

// ===== swdq_host_model.sv
// Behavioural host pod that drives and reads the single debug wire
`timescale 1ns/10ps
`default_nettype none

module swdq_host_model (
    input  wire logic sys_clk_i,  // Target bus clock, used for bit timing and the overlap count
    input  wire logic dev_lvl_i,  // Level the target drives
    input  wire logic dev_oe_i,   // Target drive enable
    output logic      wire_o      // Resolved wire level
);
    logic drv;
    logic lvl;
    logic sending;
    int   overlap;

    // ==================================================================
    // Wire resolution: pull-up wins when nobody drives
    // ==================================================================
    assign wire_o = dev_oe_i ? dev_lvl_i : (drv ? lvl : 1'b1);

    initial begin
        drv = 1'b0;
        lvl = 1'b1;
        sending = 1'b0;
        overlap = 0;
    end

    // Target must stay off the wire while the host owns the bit
    always @(posedge sys_clk_i) begin
        if (sending && dev_oe_i === 1'b1) overlap++;
    end

    // ==================================================================
    // Host to target bit: falling edge, then actively driven level
    // ==================================================================
    task automatic write_bit(input logic b);
        @(negedge sys_clk_i);
        sending = 1'b1;
        drv = 1'b1;
        lvl = 1'b0;
        repeat (b ? 4 : 15) @(negedge sys_clk_i);
        lvl = 1'b1;
        repeat (b ? 11 : 0) @(negedge sys_clk_i);
        sending = 1'b0;
        drv = 1'b0;
    endtask

    // ==================================================================
    // Target to host bit: short low pulse, release, sample near ten cycles
    // ==================================================================
    task automatic read_bit(output logic b);
        @(negedge sys_clk_i);
        drv = 1'b1;
        lvl = 1'b0;
        repeat (5) @(negedge sys_clk_i);
        drv = 1'b0;
        repeat (5) @(negedge sys_clk_i);
        b = wire_o;
        // Slower than nominal so a returned zero finishes before the next edge
        repeat (9) @(negedge sys_clk_i);
    endtask
endmodule // swdq_host_model

`default_nettype wire

// ===== swdq_top_tb_top.sv
// Self-checking bench for the debug wire link and queue status pins
`timescale 1ns/10ps
`default_nettype none

module swdq_top_tb_top;
    import swdq_pkg::*;

    logic        sys_clk_i;
    logic        rstn_i;
    logic        wire_lvl;
    logic        dev_o;
    logic        dev_oe;
    logic        mode;
    logic        rom_map;
    logic        tx_load;
    logic [15:0] tx_word;
    logic [4:0]  tx_bits;
    logic        cmd_valid;
    logic [7:0]  cmd_opcode;
    logic [15:0] rx_word;
    logic        rx_bit;
    logic        tout;
    logic        tx_busy;
    logic        phase;
    logic [15:0] bus_data;
    logic [1:0]  move_req;
    logic [1:0]  start_req;
    logic [1:0]  qstat;
    logic [7:0]  opcode;
    logic [15:0] stage2;
    int          err_total;
    int          num_checks;
    int          seed;
    int          n_cmd;
    int          n_rx;
    int          n_to;
    logic [15:0] s1;
    logic [15:0] s2;
    logic [15:0] lat;

    swdq_top i_dut (
        .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .debug_wire_pin_i(wire_lvl),
        .debug_wire_pin_o(dev_o), .debug_wire_pin_oe_o(dev_oe),
        .background_debug_mode_i(mode), .debug_rom_map_o(rom_map),
        .tx_load_i(tx_load), .tx_word_i(tx_word), .tx_bits_i(tx_bits),
        .cmd_valid_o(cmd_valid), .cmd_opcode_o(cmd_opcode), .rx_word_o(rx_word),
        .rx_bit_o(rx_bit), .link_timeout_o(tout), .tx_busy_o(tx_busy),
        .bus_phase_clock_i(phase), .bus_data_i(bus_data), .move_req_i(move_req),
        .start_req_i(start_req), .queue_status_pins_o(qstat), .opcode_o(opcode),
        .stage2_o(stage2)
    );

    swdq_host_model i_host (
        .sys_clk_i(sys_clk_i), .dev_lvl_i(dev_o), .dev_oe_i(dev_oe), .wire_o(wire_lvl)
    );

    always #12.5 sys_clk_i = ~sys_clk_i;

    always @(posedge sys_clk_i) begin
        if (cmd_valid === 1'b1) n_cmd++;
        if (rx_bit === 1'b1) n_rx++;
        if (tout === 1'b1) n_to++;
    end

    // ==================================================================
    // Checking and closing
    // ==================================================================
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic send_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) i_host.write_bit(b[i]);
    endtask

    // One bus phase period; bus data for the next step is set before the fall
    task automatic qstep(input logic [1:0] mv, input logic [1:0] st, input logic [15:0] nd);
        move_req = mv;
        start_req = st;
        phase = 1'b1;
        repeat (6) @(negedge sys_clk_i);
        if (mv == LATCH_BUS_CODE) lat = bus_data;
        if (mv[1]) begin
            s2 = s1;
            s1 = mv[0] ? lat : bus_data;
        end
        chk(16'(qstat), 16'(mv));
        chk(stage2, s2);
        bus_data = nd;
        phase = 1'b0;
        repeat (6) @(negedge sys_clk_i);
        chk(16'(qstat), 16'(st));
        if (st == EVEN_START_CODE) chk(16'(opcode), 16'(s2[15:8]));
        if (st == ODD_START_CODE) chk(16'(opcode), 16'(s2[7:0]));
    endtask

    initial begin
        repeat (100000) @(posedge sys_clk_i);
        err_total++;
        give_verdict();
    end

    // ==================================================================
    // Main sequence
    // ==================================================================
    initial begin
        logic [7:0]  op;
        logic [15:0] got;
        logic        b;
        int          c0;
        int          r0;
        int          t0;
        sys_clk_i = 1'b0;
        rstn_i = 1'b0;
        {mode, tx_load, phase, tx_word, tx_bits, bus_data, move_req, start_req} = '0;
        {err_total, num_checks, n_cmd, n_rx, n_to} = '0;
        {s1, s2, lat} = '0;
        seed = 84583;
        repeat (4) @(negedge sys_clk_i);
        rstn_i = 1'b1;
        repeat (3) @(negedge sys_clk_i);
        chk(16'({dev_oe, cmd_valid, tx_busy, rom_map}), 16'h0000);
        chk(16'(qstat), 16'h0000);
        mode = 1'b1;
        repeat (2) @(negedge sys_clk_i);
        chk(16'(rom_map), 16'h0001);
        mode = 1'b0;
        repeat (2) @(negedge sys_clk_i);
        chk(16'(rom_map), 16'h0000);
        for (int it = 0; it < 3; it++) begin
            op = (it == 0) ? 8'h80 : 8'($random(seed));
            c0 = n_cmd;
            r0 = n_rx;
            send_byte(op);
            repeat (2) @(negedge sys_clk_i);
            chk(16'(n_cmd - c0), 16'h0001);
            chk(16'(n_rx - r0), 16'h0008);
            chk(16'(cmd_opcode), 16'(op));
            chk(16'(rx_word[7:0]), 16'(op));
            chk(16'(i_host.overlap), 16'h0000);
            repeat (150) @(negedge sys_clk_i);
            tx_word = (it == 1) ? 16'h0000 : 16'($random(seed));
            tx_bits = 5'h10;
            tx_load = 1'b1;
            @(negedge sys_clk_i);
            tx_load = 1'b0;
            chk(16'(tx_busy), 16'h0001);
            for (int i = 15; i >= 0; i--) begin
                i_host.read_bit(b);
                got[i] = b;
            end
            chk(got, tx_word);
            chk(16'(tx_busy), 16'h0000);
            // Partial command left hanging so the link must time out
            for (int i = 0; i < 3; i++) i_host.write_bit(1'($random(seed)));
            t0 = n_to;
            repeat (480) @(negedge sys_clk_i);
            chk(16'(n_to - t0), 16'h0000);
            repeat (56) @(negedge sys_clk_i);
            chk(16'(n_to - t0), 16'h0001);
            chk(16'(cmd_opcode), 16'h0000);
        end
        bus_data = 16'($random(seed));
        for (int i = 0; i < 16; i++) begin
            qstep((i < 4) ? 2'(i) : 2'($random(seed)), 2'(i % 4), 16'($random(seed)));
        end
        give_verdict();
    end
endmodule // swdq_top_tb_top

`default_nettype wire
